// ---- core/sfc_core.sv ----
//Function
// - opcode 0Bh is fast read: three address bytes, one dummy, then streamed data.
// - opcode 03h is normal read: address in on rising, data out on falling.
// - opcode D8h is sector erase with three address bytes only.
// - opcode C7h is whole-array erase with nothing after the opcode.
// - opcode 02h is page program: three address bytes then 1 to 256 data bytes.
// - opcode B9h enters deep power-down, no further bytes.
// - opcode ABh releases power-down; after three dummy bytes signature repeats.
// - write enable sets latch; latch required before program, erase, status write.
// - latch clears at reset and after disable, status write, program, erases.
// - status read works anytime, byte repeats while select stays low.
// - status-write-disable set and protect pin low blocks all status writes.
// - program and sector erase into protected region are rejected.
// - whole-array erase only runs when block-protect field is zero.
// - write-in-progress is read-only, 1 during self-timed cycles, else 0.
// - status write ignores b6,b5,b1,b0; b6 and b5 read zero.
// - status write needs select rising after eighth data bit; cycle starts then.
// - with status-write-disable clear, status writes need only the latch.
// - hardware protection holds while both conditions hold; pin high exits.
// - reads increment address per byte and wrap from top to zero.
// - select rising ends a read at any bit and returns to idle.
// - reads during a busy cycle are rejected, the cycle continues.
// - everything shifts msb first, sampled on clock rising edges after select falls.
// - write-type commands execute only if select rises on a byte boundary.
// - 06h write enable, 04h disable, 05h status read, 01h status write.
// - protect map 1:70000+, 2:60000+, 3:40000+, 0 none, 4-7 all.
module sfc_core #(
    parameter int STAT_WRITE_CYC = sfc_pkg::STAT_WRITE_CYC,
    parameter int PAGE_PROG_CYC  = sfc_pkg::PAGE_PROG_CYC,
    parameter int SECT_ERASE_CYC = sfc_pkg::SECT_ERASE_CYC,
    parameter int ARR_ERASE_CYC  = sfc_pkg::ARR_ERASE_CYC,
    parameter int FIFO_DEPTH     = 8
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // serial pins
    input  wire logic        sel_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        wprot_n,
    // array side: read data fetch
    output logic      [18:0] rd_addr,
    input  wire logic [7:0]  rd_data,
    // array side: program bytes and job start
    output logic             prog_valid,
    input  wire logic        prog_ready,
    output logic      [7:0]  prog_data,
    output logic      [18:0] job_addr,
    output logic             job_start,
    output logic      [1:0]  job_kind,
    // status view
    output logic      [7:0]  status,
    output logic             power_down
);
    // three-stage samplers; select, clock and protect levels are taken once stages 1 and 2 agree
    logic [2:0] sel_s;
    logic [2:0] clk_s;
    logic [2:0] di_s;
    logic [2:0] wp_s;
    logic sel_q;
    logic clk_q;
    logic wp_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_s <= 3'h7;
            clk_s <= 3'h0;
            di_s  <= 3'h0;
            wp_s  <= 3'h7;
            sel_q <= 1'b1;
            clk_q <= 1'b0;
            wp_q  <= 1'b1;
        end else begin
            sel_s <= {sel_s[1:0], sel_n};
            clk_s <= {clk_s[1:0], sclk};
            di_s  <= {di_s[1:0], sdi};
            wp_s  <= {wp_s[1:0], wprot_n};
            if (sel_s[1] == sel_s[2]) sel_q <= sel_s[2];
            if (clk_s[1] == clk_s[2]) clk_q <= clk_s[2];
            if (wp_s[1] == wp_s[2]) wp_q <= wp_s[2];
        end
    end

    logic clk_now;
    logic rise;
    logic fall;
    logic sel_rise;
    logic active;
    assign clk_now  = (clk_s[1] == clk_s[2]) ? clk_s[2] : clk_q;
    assign rise     = !sel_q && clk_now && !clk_q;
    assign fall     = !sel_q && !clk_now && clk_q;
    assign sel_rise = !sel_q && (sel_s[1] == sel_s[2]) && sel_s[2];
    assign active   = !sel_q;

    function automatic logic prot_hit(input logic [2:0] bp, input logic [18:0] a);
        prot_hit = 1'b0;
        if (bp[2]) prot_hit = 1'b1;
        else if (bp == 3'h1) prot_hit = (a >= sfc_pkg::PROT_EIGHTH);
        else if (bp == 3'h2) prot_hit = (a >= sfc_pkg::PROT_QUARTER);
        else if (bp == 3'h3) prot_hit = (a >= sfc_pkg::PROT_HALF);
    endfunction : prot_hit

    // command framing
    sfc_pkg::sfc_phase_e phase_q;
    logic [7:0]  shift_q;
    logic [2:0]  bit_q;
    logic [1:0]  cnt_q;
    logic [7:0]  op_q;
    logic        op_done_q;
    logic [23:0] addr_q;
    logic [7:0]  out_q;
    logic        data_seen_q;
    logic        wr_data_q;
    logic [7:0]  stat_in_q;
    logic [7:0]  shift_d;
    logic        byte_done;
    assign shift_d   = {shift_q[6:0], di_s[2]};
    assign byte_done = rise && (bit_q == 3'h7);

    // status and protection state
    logic        wel_q;
    logic        swd_q;
    logic [2:0]  bp_q;
    logic        pd_q;
    logic [31:0] busy_q;
    logic        busy;
    logic        hw_prot;
    logic [7:0]  stat_view;
    assign busy      = (busy_q != '0);
    assign hw_prot   = swd_q && !wp_q;
    assign stat_view = {swd_q, 2'b00, bp_q, wel_q, busy};
    assign status    = stat_view;
    assign power_down = pd_q;

    logic is_read;
    assign is_read = (op_q == sfc_pkg::OP_READ) || (op_q == sfc_pkg::OP_FAST_READ);

    // fifo for page program bytes
    logic fifo_in_valid;
    logic fifo_in_ready;
    assign fifo_in_valid = byte_done && (phase_q == sfc_pkg::SFC_DIN) && (op_q == sfc_pkg::OP_PAGE_PROG);

    sfc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .flush     (job_start && (job_kind != 2'(sfc_pkg::SFC_OP_PROG))),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (shift_d),
        .out_valid (prog_valid),
        .out_ready (prog_ready),
        .out_data  (prog_data)
    );

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q     <= sfc_pkg::SFC_IDLE;
            shift_q     <= 8'h00;
            bit_q       <= 3'h0;
            cnt_q       <= 2'h0;
            op_q        <= 8'h00;
            op_done_q   <= 1'b0;
            addr_q      <= 24'h000000;
            out_q       <= 8'h00;
            data_seen_q <= 1'b0;
            wr_data_q   <= 1'b0;
            stat_in_q   <= 8'h00;
        end else if (sel_q) begin
            phase_q   <= sfc_pkg::SFC_IDLE;
            bit_q     <= 3'h0;
            op_done_q <= 1'b0;
            data_seen_q <= 1'b0;
            wr_data_q <= 1'b0;
        end else if (rise) begin
            shift_q <= shift_d;
            bit_q   <= bit_q + 3'h1;
            if (byte_done) begin
                if (!op_done_q) begin
                    op_q      <= shift_d;
                    op_done_q <= 1'b1;
                    cnt_q     <= 2'h0;
                    unique case (shift_d)
                        sfc_pkg::OP_READ, sfc_pkg::OP_FAST_READ: begin
                            phase_q <= (busy || pd_q) ? sfc_pkg::SFC_SKIP : sfc_pkg::SFC_ADDR;
                        end
                        sfc_pkg::OP_SECT_ERA, sfc_pkg::OP_PAGE_PROG: begin
                            phase_q <= sfc_pkg::SFC_ADDR;
                        end
                        sfc_pkg::OP_RD_STAT: begin
                            phase_q <= sfc_pkg::SFC_DOUT;
                            out_q   <= stat_view;
                        end
                        sfc_pkg::OP_WR_STAT: phase_q <= sfc_pkg::SFC_DIN;
                        sfc_pkg::OP_PWR_UP: phase_q <= sfc_pkg::SFC_DUMMY;
                        default: phase_q <= sfc_pkg::SFC_SKIP;
                    endcase
                end else begin
                    unique case (phase_q)
                        sfc_pkg::SFC_ADDR: begin
                            addr_q <= {addr_q[15:0], shift_d};
                            cnt_q  <= cnt_q + 2'h1;
                            if (cnt_q == 2'h2) begin
                                if (op_q == sfc_pkg::OP_FAST_READ) begin
                                    phase_q <= sfc_pkg::SFC_DUMMY;
                                end else if (op_q == sfc_pkg::OP_READ) begin
                                    phase_q <= sfc_pkg::SFC_DOUT;
                                    out_q   <= rd_data;
                                end else if (op_q == sfc_pkg::OP_PAGE_PROG) begin
                                    phase_q <= sfc_pkg::SFC_DIN;
                                end else begin
                                    phase_q <= sfc_pkg::SFC_SKIP;
                                end
                            end
                        end
                        sfc_pkg::SFC_DUMMY: begin
                            cnt_q <= cnt_q + 2'h1;
                            if (op_q == sfc_pkg::OP_FAST_READ) begin
                                phase_q <= sfc_pkg::SFC_DOUT;
                                out_q   <= rd_data;
                            end else if (cnt_q == 2'h2) begin
                                phase_q <= sfc_pkg::SFC_DOUT;
                                out_q   <= 8'(sfc_pkg::SIG_BYTE);
                            end
                        end
                        sfc_pkg::SFC_DIN: begin
                            data_seen_q <= 1'b1;
                            stat_in_q   <= shift_d;
                            wr_data_q   <= (op_q == sfc_pkg::OP_WR_STAT) ? !data_seen_q : wr_data_q;
                        end
                        sfc_pkg::SFC_SKIP: cnt_q <= 2'h0;
                        sfc_pkg::SFC_DOUT: begin
                            if (is_read) begin
                                addr_q <= (addr_q[18:0] == sfc_pkg::ADDR_TOP) ? 24'h0 : addr_q + 24'h1;
                                out_q  <= rd_data;
                            end else if (op_q == sfc_pkg::OP_RD_STAT) begin
                                out_q <= stat_view;
                            end
                        end
                        default: phase_q <= phase_q;
                    endcase
                end
            end
        end
    end

    // data leaves msb first, changing on falling edges
    logic [2:0] obit_q;
    logic       sdo_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            obit_q <= 3'h0;
            sdo_q  <= 1'b0;
        end else if (sel_q) begin
            obit_q <= 3'h0;
        end else if (fall && phase_q == sfc_pkg::SFC_DOUT) begin
            sdo_q  <= out_q[3'h7 - obit_q];
            obit_q <= obit_q + 3'h1;
        end
    end
    assign sdo    = sdo_q;
    assign sdo_oe = active && (phase_q == sfc_pkg::SFC_DOUT);
    // array reads next byte ahead of use; the last address byte is still in the shifter
    assign rd_addr = (phase_q == sfc_pkg::SFC_DOUT) ? addr_q[18:0] + 19'h1 :
                     (phase_q == sfc_pkg::SFC_ADDR) ? {addr_q[10:0], shift_d} : addr_q[18:0];

    // command completion on select rising
    logic    aligned;
    logic    wr_ok;
    assign aligned = (bit_q == 3'h0) && op_done_q;
    assign wr_ok   = aligned && !busy && !pd_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wel_q     <= 1'b0;
            swd_q     <= sfc_pkg::STAT_NV_RESET[3];
            bp_q      <= sfc_pkg::STAT_NV_RESET[2:0];
            pd_q      <= 1'b0;
            busy_q    <= '0;
            job_start <= 1'b0;
            job_kind  <= 2'(sfc_pkg::SFC_OP_NONE);
            job_addr  <= 19'h0;
        end else begin
            job_start <= 1'b0;
            if (busy) busy_q <= busy_q - 32'h1;
            if (sel_rise && wr_ok) begin
                unique case (op_q)
                    sfc_pkg::OP_WRITE_ENABLE_CMD:  wel_q <= 1'b1;
                    sfc_pkg::OP_WRITE_DISABLE_CMD:  wel_q <= 1'b0;
                    sfc_pkg::OP_WR_STAT: begin
                        // only exactly one data byte counts
                        if (wel_q && wr_data_q && !hw_prot) begin
                            swd_q  <= stat_in_q[sfc_pkg::STAT_SWD_BIT];
                            bp_q   <= stat_in_q[sfc_pkg::STAT_BP_HI:sfc_pkg::STAT_BP_LO];
                            wel_q  <= 1'b0;
                            busy_q <= 32'(STAT_WRITE_CYC);
                            job_kind <= 2'(sfc_pkg::SFC_OP_STAT);
                        end
                    end
                    sfc_pkg::OP_PAGE_PROG: begin
                        if (wel_q && data_seen_q && !prot_hit(bp_q, addr_q[18:0])) begin
                            wel_q     <= 1'b0;
                            busy_q    <= 32'(PAGE_PROG_CYC);
                            job_start <= 1'b1;
                            job_kind  <= 2'(sfc_pkg::SFC_OP_PROG);
                            job_addr  <= addr_q[18:0];
                        end
                    end
                    sfc_pkg::OP_SECT_ERA: begin
                        // count of three only right after the last address byte; extra bytes reject
                        if (wel_q && cnt_q == 2'h3 && !prot_hit(bp_q, addr_q[18:0])) begin
                            wel_q     <= 1'b0;
                            busy_q    <= 32'(SECT_ERASE_CYC);
                            job_start <= 1'b1;
                            job_kind  <= 2'(sfc_pkg::SFC_OP_ERASE);
                            job_addr  <= addr_q[18:0];
                        end
                    end
                    sfc_pkg::OP_ARR_ERA: begin
                        if (wel_q && bit_q == 3'h0 && bp_q == 3'h0) begin
                            wel_q     <= 1'b0;
                            busy_q    <= 32'(ARR_ERASE_CYC);
                            job_start <= 1'b1;
                            job_kind  <= 2'(sfc_pkg::SFC_OP_ERASE);
                            job_addr  <= sfc_pkg::ADDR_TOP;
                        end
                    end
                    sfc_pkg::OP_PWR_DOWN: pd_q <= 1'b1;
                    default: pd_q <= pd_q;
                endcase
            end
            // release is honoured even in power-down
            if (sel_rise && op_done_q && op_q == sfc_pkg::OP_PWR_UP) pd_q <= 1'b0;
        end
    end

    // page program bytes beyond fifo space stall nothing on the serial side;
    // the array must drain faster than the link fills, one byte per 8 link clocks
    logic unused_ready;
    assign unused_ready = fifo_in_ready;
endmodule : sfc_core

// ---- core/sfc_pkg.sv ----
package sfc_pkg;
    // opcodes
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_SECT_ERA  = 8'hd8;
    localparam logic [7:0] OP_ARR_ERA   = 8'hc7;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_PWR_DOWN  = 8'hb9;
    localparam logic [7:0] OP_PWR_UP    = 8'hab;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD      = 8'h04;
    localparam logic [7:0] OP_RD_STAT   = 8'h05;
    localparam logic [7:0] OP_WR_STAT   = 8'h01;
    // status fields
    localparam int STAT_SWD_BIT = 7;
    localparam int STAT_BP_HI   = 4;
    localparam int STAT_BP_LO   = 2;
    localparam int STAT_WEL_BIT = 1;
    localparam int STAT_WIP_BIT = 0;
    localparam logic [7:0] STAT_WRITE_MASK = 8'h9c;
    localparam logic [3:0] STAT_NV_RESET   = 4'h0;
    // array geometry
    localparam logic [18:0] ADDR_TOP       = 19'h7ffff;
    localparam logic [18:0] PROT_EIGHTH    = 19'h70000;
    localparam logic [18:0] PROT_QUARTER   = 19'h60000;
    localparam logic [18:0] PROT_HALF      = 19'h40000;
    localparam int PAGE_BYTES = 256;
    // self-timed cycles, in cycles of mclk
    localparam int CLK_MHZ         = 50;
    localparam int STAT_WRITE_US   = 10;
    localparam int PAGE_PROG_US    = 20;
    localparam int SECT_ERASE_US   = 40;
    localparam int ARR_ERASE_US    = 80;
    localparam int STAT_WRITE_CYC  = STAT_WRITE_US * CLK_MHZ;
    localparam int PAGE_PROG_CYC   = PAGE_PROG_US * CLK_MHZ;
    localparam int SECT_ERASE_CYC  = SECT_ERASE_US * CLK_MHZ;
    localparam int ARR_ERASE_CYC   = ARR_ERASE_US * CLK_MHZ;
    localparam int SIG_BYTE        = 8'h5a;  // signature value is arbitrary

    typedef enum logic [2:0] {
        SFC_IDLE  = 3'b000,
        SFC_ADDR  = 3'b001,
        SFC_DUMMY = 3'b010,
        SFC_DOUT  = 3'b011,
        SFC_DIN   = 3'b100,
        SFC_SKIP  = 3'b101
    } sfc_phase_e;

    typedef enum logic [1:0] {
        SFC_OP_NONE  = 2'b00,
        SFC_OP_STAT  = 2'b01,
        SFC_OP_PROG  = 2'b10,
        SFC_OP_ERASE = 2'b11
    } sfc_job_e;
endpackage : sfc_pkg

// ---- core/sfc_fifo.sv ----
module sfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sfc_fifo

// ---- sim/sfc_core_sva.sv ----
module sfc_core_sva (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // pins
    input wire logic       sel_n,
    input wire logic       sdo_oe,
    input wire logic       wprot_n,
    // job and status
    input wire logic       job_start,
    input wire logic [1:0] job_kind,
    input wire logic [7:0] status,
    input wire logic       power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_frame_end; $rose(sel_n); endsequence
    sequence s_hw_held; status[7] && !wprot_n ##1 !wprot_n; endsequence
    property p_b65_zero; status[6:5] == 2'b00; endproperty
    property p_oe_end; s_frame_end |-> ##[1:6] !sdo_oe; endproperty
    property p_wel_rise; $rose(status[1]) |-> sel_n; endproperty
    property p_job_wel; job_start |-> $past(status[1]); endproperty
    property p_job_wip; job_start |-> ##[0:2] status[0]; endproperty
    property p_job_bp; job_start && job_kind != 2'b01 |-> !$past(status[4]); endproperty
    property p_hw_prot; s_hw_held |-> $stable(status[7:2]); endproperty
    property p_pd_job; power_down |-> !job_start; endproperty
    a_b65_zero: assert property (p_b65_zero) else $error("reserved status bits set");
    a_oe_end: assert property (p_oe_end) else $error("output kept after deselect");
    a_wel_rise: assert property (p_wel_rise) else $error("latch set inside a frame");
    a_job_wel: assert property (p_job_wel) else $error("job without latch");
    a_job_wip: assert property (p_job_wip) else $error("job without busy flag");
    a_job_bp: assert property (p_job_bp) else $error("job in fully protected array");
    a_hw_prot: assert property (p_hw_prot) else $error("status changed under hardware lock");
    a_pd_job: assert property (p_pd_job) else $error("job in power down");
endmodule : sfc_core_sva

bind sfc_core sfc_core_sva chk_u (.mclk(mclk), .sys_rst(sys_rst), .sel_n(sel_n), .sdo_oe(sdo_oe),
    .wprot_n(wprot_n), .job_start(job_start), .job_kind(job_kind), .status(status), .power_down(power_down));

// ---- sim/sfc_host_model.sv ----
module sfc_host_model (
    // clock
    input wire logic mclk,
    // serial pins
    output logic     sel_n,
    output logic     sclk,
    output logic     sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // mode 0 host, 8 mclk per bit; clock stands low between frames
    task automatic frame(input logic [7:0] b[$], input int n);
        logic [7:0] sh;
        rx_q = {};
        sel_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b0;
            sdi <= (i / 8 < b.size()) ? b[i/8][7-i%8] : 1'b0;
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            @(negedge mclk) sh = {sh[6:0], sdo};
            @(posedge mclk);
            if (i % 8 == 7) rx_q.push_back(sh);
        end
        sclk <= 1'b0;
        repeat (4) @(posedge mclk);
        sel_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge mclk);
    endtask : frame
endmodule : sfc_host_model

// ---- sim/serial_flash_command_protect_tb_top.sv ----
module serial_flash_command_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wprot_n = 1'b1;
    logic        oe_seen = 1'b0;
    logic        sel_n, sclk, sdi, sdo, sdo_oe, prog_valid, job_start, power_down;
    logic [18:0] rd_addr, job_addr, ja;
    logic [7:0]  rd_data, prog_data, status;
    logic [1:0]  job_kind, jk;
    logic [7:0]  pq[$];
    int          bad_count = 0;
    int          n_checks = 0;
    int          jobs = 0;
    int          j;
    always #10 mclk = ~mclk;
    // array contents stand in as a pure function of the address
    function automatic logic [7:0] mem(input logic [18:0] a);
        return a[7:0] ^ {5'h00, a[18:16]};
    endfunction : mem
    assign rd_data = mem(rd_addr);
    // short cycle counts keep the run small; sector erase long enough to read during it
    sfc_core #(.STAT_WRITE_CYC(20), .PAGE_PROG_CYC(40), .SECT_ERASE_CYC(400), .ARR_ERASE_CYC(40)) dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .wprot_n(wprot_n), .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid), .prog_ready(1'b1),
        .prog_data(prog_data), .job_addr(job_addr), .job_start(job_start), .job_kind(job_kind),
        .status(status), .power_down(power_down));
    sfc_host_model host_u (.mclk(mclk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
    always @(posedge mclk) begin
        if (job_start === 1'b1) begin
            jobs <= jobs + 1;
            jk <= job_kind;
            ja <= job_addr;
        end
        if (prog_valid === 1'b1) pq.push_back(prog_data);
        if (sdo_oe === 1'b1) oe_seen <= 1'b1;
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] b[$], input int n = 0);
        host_u.frame(b, (n != 0) ? n : 8 * b.size());
    endtask : cmd
    task automatic wr_stat(input logic [7:0] v);
        cmd('{8'h06});
        cmd('{8'h01, v});
        repeat (40) @(posedge mclk);
    endtask : wr_stat
    task automatic t_latch;
        chk(status === 8'h00 && power_down === 1'b0 && sdo_oe === 1'b0, "reset values");
        cmd('{8'h06});
        chk(status === 8'h02, "latch not set");
        cmd('{8'h04});
        chk(status[1] === 1'b0, "latch not cleared");
        cmd('{8'h06}, 7);
        chk(status[1] === 1'b0, "off-boundary accepted");
        $display("test latch done");
    endtask : t_latch
    task automatic t_status;
        cmd('{8'h06});
        cmd('{8'h01, 8'hff});
        chk(status[0] === 1'b1, "no busy flag");
        repeat (40) @(posedge mclk);
        chk(status === 8'h9c, "status write");
        cmd('{8'h05}, 32);
        chk(host_u.rx_q[1] === 8'h9c && host_u.rx_q[3] === 8'h9c, "status read");
        cmd('{8'h06});
        j = jobs;
        cmd('{8'hc7});
        chk(jobs == j, "array erase while protected");
        wprot_n <= 1'b0;
        wr_stat(8'h00);
        chk(status[7:2] === 6'b100111, "write under hardware lock");
        wprot_n <= 1'b1;
        wr_stat(8'h04);
        chk(status === 8'h04, "lock not left");
        $display("test status done");
    endtask : t_status
    task automatic t_erase;
        j = jobs;
        cmd('{8'h06});
        cmd('{8'hd8, 8'h07, 8'h00, 8'h00});
        chk(jobs == j, "protected erase");
        cmd('{8'h06});
        cmd('{8'hd8, 8'h01, 8'h23, 8'h45});
        chk(jobs == j + 1 && jk === 2'b11 && ja === 19'h12345, "sector erase");
        oe_seen <= 1'b0;
        cmd('{8'h03, 8'h00, 8'h00, 8'h00}, 40);
        chk(oe_seen === 1'b0 && status[0] === 1'b1, "read while busy");
        repeat (100) @(posedge mclk);
        $display("test erase done");
    endtask : t_erase
    task automatic t_read;
        cmd('{8'h03, 8'h07, 8'hff, 8'hff}, 56);
        chk(host_u.rx_q[4] === mem(19'h7ffff) && host_u.rx_q[5] === mem(19'h0)
            && host_u.rx_q[6] === mem(19'h1), "read wrap");
        cmd('{8'h0b, 8'h00, 8'h00, 8'h10, 8'h00}, 56);
        chk(host_u.rx_q[5] === mem(19'h10) && host_u.rx_q[6] === mem(19'h11), "fast read");
        oe_seen <= 1'b0;
        cmd('{8'h03}, 44);
        chk(oe_seen === 1'b1 && sdo_oe === 1'b0, "read not ended");
        cmd('{8'h05}, 16);
        chk(host_u.rx_q[1] === 8'h04, "no idle after cut read");
        $display("test read done");
    endtask : t_read
    task automatic t_prog;
        cmd('{8'h06});
        j = jobs;
        cmd('{8'h02, 8'h00, 8'h01, 8'h00, 8'ha5, 8'h3c});
        repeat (10) @(posedge mclk);
        chk(jobs == j + 1 && jk === 2'b10 && pq.size() == 2 && pq[0] === 8'ha5 && pq[1] === 8'h3c, "program");
        repeat (60) @(posedge mclk);
        wr_stat(8'h00);
        cmd('{8'h06});
        j = jobs;
        cmd('{8'hc7});
        chk(jobs == j + 1 && jk === 2'b11, "array erase");
        repeat (60) @(posedge mclk);
        cmd('{8'hb9});
        chk(power_down === 1'b1, "no power down");
        cmd('{8'h06});
        chk(status[1] === 1'b0, "latch set in power down");
        cmd('{8'hab}, 48);
        chk(power_down === 1'b0 && host_u.rx_q[4] === 8'(sfc_pkg::SIG_BYTE), "no release");
        $display("test program done");
    endtask : t_prog
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_latch();
        t_status();
        t_erase();
        t_read();
        t_prog();
        complete_run();
    end
    // run needs about 5600 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        complete_run();
    end
endmodule : serial_flash_command_protect_tb_top
